// ### pkg/ppc_consts.vh
// Constants for the parallel port handshake controller.
// Behaviour
// RULE1: Bidirectional mode exists on port 0 only.
// RULE2: Bidirectional mode uses port 2 bits 3-7.
// RULE3: Bidirectional keeps separate port 0 in/out latches.
// RULE4: Bidirectional drives port 0 only while accept low.
// RULE5: Second port 0 address gives synchronized access.
// RULE6: Synchronized read stalls until new strobed data.
// RULE7: Sync accesses complete on irq line rising.
// RULE8: Mode 4: handshake output, control bits 3,6,7.
// RULE9: Mode 7: handshake input, control bits 3,4,5.
// RULE10: Group B mode 0: port1, port2 low outputs.
// RULE11: Group A handshake keeps port 2 bit 3.
// RULE12: Immediate read and write of every port.
// RULE13: Modes 4,6: port 2 write keeps bits 4-7.
// RULE14: Single bit set and clear on port 2.
// RULE15: Strobe low loads input latch, raises full flag; code raises it only once BUF_DEPTH entries are held.
// RULE16: Output full flag: low on write, high on accept.
// RULE17: Port 2 bit 4 or 6 gates the irq.
// RULE18: New configure command clears interrupt enables.
// RULE19: Group B codes 5 and 7 are ignored.
// RULE20: Sync access holds ready until completing edge.
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH
// Processor addresses of the ports and commands.
`define PPC_ADDR_P0 16'h1C00
`define PPC_ADDR_P1 16'h1C01
`define PPC_ADDR_P2 16'h1C02
`define PPC_ADDR_CFG 16'h1C03
`define PPC_ADDR_BIT 16'h1C04
`define PPC_ADDR_SYNC 16'h5C00
// Port 2 handshake bit positions.
`define PPC_B_IRQ 3
`define PPC_B_STB 4
`define PPC_B_IBF 5
`define PPC_B_ACK 6
`define PPC_B_OBF 7
// Bit command fields: bit 7 chooses set, bits 2..0 the index.
`define PPC_BIT_SETSEL 7
// Group mode codes.
`define PPC_MODE_HSO_A 4'h4
`define PPC_MODE_HSO_B 4'h5
`define PPC_MODE_HSI_A 4'h6
`define PPC_MODE_HSI_B 4'h7
`define PPC_MODE_BIDIR 4'h8
`define PPC_MODE_LAST_SIMPLE 4'h3
// Reset values.
`define PPC_RST_MODE 4'h3
`define PPC_RST_BYTE 8'h00
`endif

// ### logic/ppc_port_controller.v
// Three-port parallel controller with handshake, bidirectional and sync modes.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_consts.vh"

module ppc_port_controller #(
	parameter BUF_AW = 1
) (
	// Clock and reset.
	input wire i_sys_clk,
	input wire i_reset,
	// Processor access port.
	input wire i_bus_rd,
	input wire i_bus_wr,
	input wire [15:0] i_bus_addr,
	input wire [7:0] i_bus_wdata,
	output reg [7:0] o_bus_rdata,
	output reg o_bus_ready,
	// Port 0 pins.
	input wire [7:0] i_p0_in,
	output reg [7:0] o_p0_out,
	output reg [7:0] o_p0_oe,
	// Port 1 pins.
	input wire [7:0] i_p1_in,
	output reg [7:0] o_p1_out,
	output reg [7:0] o_p1_oe,
	// Port 2 pins, handshake lines among them.
	input wire [7:0] i_p2_in,
	output reg [7:0] o_p2_out,
	output reg [7:0] o_p2_oe
);

	// Bus sequencer states.
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_SYNC_RD = 2'b01;
	localparam [1:0] ST_SYNC_WR = 2'b10;
	localparam BUF_DEPTH = 1 << BUF_AW;

	// True when a group A code selects a handshake output mode.
	function hs_out;
		input [3:0] m;
		begin
			hs_out = (m == `PPC_MODE_HSO_A) || (m == `PPC_MODE_HSO_B);
		end
	endfunction

	// True when a group A code selects a handshake input mode.
	function hs_in;
		input [3:0] m;
		begin
			hs_in = (m == `PPC_MODE_HSI_A) || (m == `PPC_MODE_HSI_B);
		end
	endfunction

	reg [3:0] amode_q; // Group A mode code.
	reg [3:0] bmode_q; // Group B mode code.
	reg [7:0] p0_lat_q; // Port 0 output latch.
	reg [7:0] p1_lat_q; // Port 1 output latch.
	reg [7:0] p2_lat_q; // Port 2 latch; bits 4 and 6 double as enables.
	reg [7:0] buf_q [0:BUF_DEPTH-1]; // Port 0 input buffer entries.
	reg [BUF_AW-1:0] wp_q; // Buffer write index.
	reg [BUF_AW-1:0] rp_q; // Buffer read index.
	reg [BUF_AW:0] cnt_q; // Entries held in the buffer.
	reg obf_n_q; // Output full flag, low while data waits.
	reg out_done_q; // Peripheral took the last output byte.
	reg stb_prev_q; // Load strobe one clock ago.
	reg ack_prev_q; // Accept strobe one clock ago.
	reg irq_prev_q; // Raw request level one clock ago.
	reg [1:0] state_q; // Bus sequencer state.
	reg [7:0] sdata_q; // Data held for a pending sync write.

	wire a_out = hs_out(amode_q) || (amode_q == `PPC_MODE_BIDIR);
	wire a_in = hs_in(amode_q) || (amode_q == `PPC_MODE_BIDIR);
	wire a_hs = a_out || a_in;
	wire a_bidir = (amode_q == `PPC_MODE_BIDIR);
	wire buf_has = (cnt_q != 0);
	wire buf_full = (cnt_q == BUF_DEPTH); // RULE15
	wire [7:0] buf_head = buf_q[rp_q];
	wire idle = (state_q == ST_IDLE);
	wire rd_now = idle && i_bus_rd;
	wire wr_now = idle && i_bus_wr;

	// Raw request before the enable gating; bit 3 shows the gated level, sync access waits on the raw one.
	wire irq_in = buf_has && i_p2_in[`PPC_B_STB]; // RULE6
	wire irq_out = out_done_q;
	wire irq_raw = (a_in && irq_in) || (a_out && irq_out);
	wire irq_rise = irq_raw && !irq_prev_q; // RULE7
	// The gated level that the pin shows.
	wire irq_pin = (a_in && irq_in && p2_lat_q[`PPC_B_STB]) ||
		(a_out && irq_out && p2_lat_q[`PPC_B_ACK]); // RULE17

	// Peripheral strobe edges; pins are already in this clock's domain.
	wire stb_fall = stb_prev_q && !i_p2_in[`PPC_B_STB];
	wire ack_fall = ack_prev_q && !i_p2_in[`PPC_B_ACK];

	// Completion of the two kinds of sync access.
	wire sync_rd_done = (state_q == ST_SYNC_RD) && irq_rise; // RULE6
	wire sync_wr_done = (state_q == ST_SYNC_WR) && irq_rise; // RULE7

	// Port 0 latch loads from an immediate or a completed sync write.
	wire p0_wr = (wr_now && (i_bus_addr == `PPC_ADDR_P0)) || sync_wr_done;
	wire [7:0] p0_wdata = sync_wr_done ? sdata_q : i_bus_wdata;
	// A port 0 read in an input handshake mode consumes one entry.
	wire p0_rd = (rd_now && (i_bus_addr == `PPC_ADDR_P0)) || sync_rd_done;
	wire pop = p0_rd && a_in && buf_has;
	// A strobe into a full buffer is the peripheral's fault and is dropped.
	wire push = a_in && stb_fall && !buf_full; // RULE15
	wire cfg_wr = wr_now && (i_bus_addr == `PPC_ADDR_CFG);
	wire [3:0] cfg_a = i_bus_wdata[7:4];
	wire [3:0] cfg_b = i_bus_wdata[3:0];

	// Direction picks for the simple modes.
	wire a_p0_out = (amode_q == 4'h0) || (amode_q == 4'h1);
	wire a_up_out = (amode_q == 4'h0) || (amode_q == 4'h2);
	wire b_p1_out = (bmode_q == 4'h0) || (bmode_q == 4'h1); // RULE10
	wire b_lo_out = (bmode_q == 4'h0) || (bmode_q == 4'h2); // RULE10

	// Next values for the pin registers.
	reg [7:0] p0_oe_d;
	reg [3:0] up_oe_d;
	reg [7:0] p2_oe_d;
	reg [7:0] p2_out_d;
	reg [7:0] rdata_d;

	// Port 0 drive: handshake output drives the latch, bidir only on accept.
	always @*
	begin
		if (a_bidir)
			p0_oe_d = {8{!i_p2_in[`PPC_B_ACK]}}; // RULE4 RULE1
		else if (a_out)
			p0_oe_d = 8'hFF;
		else if (a_in)
			p0_oe_d = 8'h00;
		else
			p0_oe_d = {8{a_p0_out}};
	end

	// Upper port 2 directions follow the group A mode table.
	always @*
	begin
		case (amode_q)
			`PPC_MODE_HSO_A: up_oe_d = 4'hB; // RULE8
			`PPC_MODE_HSO_B: up_oe_d = 4'h8;
			`PPC_MODE_HSI_A: up_oe_d = 4'hE;
			`PPC_MODE_HSI_B: up_oe_d = 4'h2; // RULE9
			`PPC_MODE_BIDIR: up_oe_d = 4'hA; // RULE2
			default: up_oe_d = {4{a_up_out}};
		endcase
	end

	// Full port 2 drive; bit 3 belongs to group A in any handshake mode.
	always @*
	begin
		p2_oe_d = {up_oe_d, a_hs ? 1'b1 : b_lo_out, {3{b_lo_out}}}; // RULE11
		p2_out_d = p2_lat_q;
		if (a_hs)
			p2_out_d[`PPC_B_IRQ] = irq_pin; // RULE17
		if (a_in)
			p2_out_d[`PPC_B_IBF] = buf_full; // RULE15
		if (a_out)
			p2_out_d[`PPC_B_OBF] = obf_n_q; // RULE16
	end

	// Read data mux; input latches and output latches stay apart.
	always @*
	begin
		rdata_d = `PPC_RST_BYTE;
		if (sync_rd_done)
			rdata_d = buf_head; // RULE6
		else if (rd_now)
		begin
			case (i_bus_addr)
				`PPC_ADDR_P0:
				begin
					if (a_in)
						rdata_d = buf_head; // RULE3
					else if (a_p0_out || a_out)
						rdata_d = p0_lat_q;
					else
						rdata_d = i_p0_in; // RULE12
				end
				`PPC_ADDR_P1:
					rdata_d = b_p1_out ? p1_lat_q : i_p1_in; // RULE12
				`PPC_ADDR_P2:
					rdata_d = (o_p2_oe & o_p2_out) | (~o_p2_oe & i_p2_in);
				`PPC_ADDR_CFG:
					rdata_d = {amode_q, bmode_q};
				default:
					rdata_d = `PPC_RST_BYTE;
			endcase
		end
	end

	// Bus sequencer: immediate accesses answer next clock, sync ones wait.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_q <= ST_IDLE;
			sdata_q <= `PPC_RST_BYTE;
			o_bus_ready <= 1'b0;
			o_bus_rdata <= `PPC_RST_BYTE;
		end
		else
		begin
			o_bus_rdata <= rdata_d;
			o_bus_ready <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					// The sync window stalls instead of answering.
					if ((i_bus_rd || i_bus_wr) &&
						(i_bus_addr == `PPC_ADDR_SYNC)) // RULE5
					begin
						state_q <= i_bus_rd ? ST_SYNC_RD : ST_SYNC_WR;
						sdata_q <= i_bus_wdata;
					end
					else if (i_bus_rd || i_bus_wr)
						o_bus_ready <= 1'b1; // RULE12
				end
				ST_SYNC_RD, ST_SYNC_WR:
				begin
					// Ready stays low until the request line rises.
					if (irq_rise)
					begin
						state_q <= ST_IDLE;
						o_bus_ready <= 1'b1; // RULE20
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Configuration: reserved codes leave the old setting in place.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			amode_q <= `PPC_RST_MODE;
			bmode_q <= `PPC_RST_MODE;
		end
		else if (cfg_wr)
		begin
			if (cfg_a <= `PPC_MODE_BIDIR)
				amode_q <= cfg_a;
			// Port 1 handshake codes are not carried, so only simple codes load.
			if (cfg_b <= `PPC_MODE_LAST_SIMPLE)
				bmode_q <= cfg_b; // RULE19
		end
	end

	// Port output latches and the port 2 bit commands.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			p0_lat_q <= `PPC_RST_BYTE;
			p1_lat_q <= `PPC_RST_BYTE;
			p2_lat_q <= `PPC_RST_BYTE;
		end
		else
		begin
			if (p0_wr)
				p0_lat_q <= p0_wdata; // RULE3
			if (wr_now && (i_bus_addr == `PPC_ADDR_P1))
				p1_lat_q <= i_bus_wdata; // RULE12
			if (wr_now && (i_bus_addr == `PPC_ADDR_P2))
			begin
				// Upper bits in modes 4 and 6 change only bit by bit.
				if ((amode_q == `PPC_MODE_HSO_A) ||
					(amode_q == `PPC_MODE_HSI_A))
					p2_lat_q[3:0] <= i_bus_wdata[3:0]; // RULE13
				else
					p2_lat_q <= i_bus_wdata;
			end
			else if (wr_now && (i_bus_addr == `PPC_ADDR_BIT))
				p2_lat_q[i_bus_wdata[2:0]] <=
					i_bus_wdata[`PPC_BIT_SETSEL]; // RULE14
			else if (cfg_wr)
			begin
				// A fresh configuration starts with interrupts gated off.
				p2_lat_q[`PPC_B_STB] <= 1'b0; // RULE18
				p2_lat_q[`PPC_B_ACK] <= 1'b0; // RULE18
			end
		end
	end

	// Output handshake flags; a new byte beats an accept in the same clock for the full flag, the accept wins for the done flag.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			obf_n_q <= 1'b1;
			out_done_q <= 1'b0;
		end
		else if (cfg_wr)
		begin
			obf_n_q <= 1'b1;
			out_done_q <= 1'b0;
		end
		else
		begin
			if (a_out && p0_wr)
				obf_n_q <= 1'b0; // RULE16
			else if (a_out && ack_fall)
				obf_n_q <= 1'b1; // RULE16
			// The accept event sets and wins over the clearing write.
			if (a_out && ack_fall && !obf_n_q)
				out_done_q <= 1'b1;
			else if (a_out && p0_wr)
				out_done_q <= 1'b0;
		end
	end

	// BUF_DEPTH-entry input buffer, two entries at the default BUF_AW of 1; its full state is the input full flag.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wp_q <= {BUF_AW{1'b0}};
			rp_q <= {BUF_AW{1'b0}};
			cnt_q <= {(BUF_AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	// Buffer storage; entries need no reset since the count guards them.
	always @(posedge i_sys_clk)
	begin
		if (push)
			buf_q[wp_q] <= i_p0_in; // RULE15
	end

	// Edge history and registered pin drive.
	always @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			stb_prev_q <= 1'b1;
			ack_prev_q <= 1'b1;
			irq_prev_q <= 1'b0;
			o_p0_out <= `PPC_RST_BYTE;
			o_p0_oe <= `PPC_RST_BYTE;
			o_p1_out <= `PPC_RST_BYTE;
			o_p1_oe <= `PPC_RST_BYTE;
			o_p2_out <= `PPC_RST_BYTE;
			o_p2_oe <= `PPC_RST_BYTE;
		end
		else
		begin
			stb_prev_q <= i_p2_in[`PPC_B_STB];
			ack_prev_q <= i_p2_in[`PPC_B_ACK];
			irq_prev_q <= irq_raw;
			o_p0_out <= p0_lat_q;
			o_p0_oe <= p0_oe_d;
			o_p1_out <= p1_lat_q;
			o_p1_oe <= {8{b_p1_out}};
			o_p2_out <= p2_out_d;
			o_p2_oe <= p2_oe_d;
		end
	end

endmodule // ppc_port_controller
`default_nettype wire

// ### tb/ppc_port_controller_chk.sv
// Concurrent checks on the port controller's pins and bus answers.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_consts.vh"
module ppc_chk #(
	parameter BUF_AW = 1
) (
	// Clock, reset and processor access port.
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_bus_rd,
	input wire i_bus_wr,
	input wire [15:0] i_bus_addr,
	input wire [7:0] i_bus_wdata,
	input wire [7:0] o_bus_rdata,
	input wire o_bus_ready,
	// Port pins.
	input wire [7:0] i_p0_in,
	input wire [7:0] o_p0_out,
	input wire [7:0] o_p0_oe,
	input wire [7:0] i_p1_in,
	input wire [7:0] o_p1_out,
	input wire [7:0] o_p1_oe,
	input wire [7:0] i_p2_in,
	input wire [7:0] o_p2_out,
	input wire [7:0] o_p2_oe
);
	logic pend_q; // A synchronized access is waiting.
	logic [3:0] am_q; // Group A mode as held by the controller.
	logic [3:0] bm_q; // Group B mode as held by the controller.
	wire req = (i_bus_rd | i_bus_wr) & ~pend_q; // Request taken.
	wire wr_of = req & i_bus_wr; // Write taken.
	// Mirror the modes; a pending sync access hides later requests.
	always_ff @(posedge i_sys_clk or posedge i_reset)
		if (i_reset)
		begin
			pend_q <= 1'b0;
			am_q <= `PPC_RST_MODE;
			bm_q <= `PPC_RST_MODE;
		end
		else
		begin
			if (req && i_bus_addr == `PPC_ADDR_SYNC)
				pend_q <= 1'b1;
			else if (o_bus_ready)
				pend_q <= 1'b0;
			if (wr_of && i_bus_addr == `PPC_ADDR_CFG)
			begin
				if (i_bus_wdata[7:4] <= `PPC_MODE_BIDIR)
					am_q <= i_bus_wdata[7:4];
				if (i_bus_wdata[3:0] <= `PPC_MODE_LAST_SIMPLE)
					bm_q <= i_bus_wdata[3:0];
			end
		end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	a_imm_answer:
		assert property (req && i_bus_addr != `PPC_ADDR_SYNC |=> o_bus_ready)
		else $error("immediate access not answered");
	a_mode4_pins:
		assert property (am_q == 4'h4 && $past(am_q) == 4'h4 |->
			o_p0_oe == 8'hFF && o_p2_oe[7:3] == 5'h17)
		else $error("mode 4 pin directions wrong");
	a_mode7_pins:
		assert property (am_q == 4'h7 && $past(am_q) == 4'h7 |->
			o_p0_oe == 8'h00 && o_p2_oe[7:3] == 5'h05)
		else $error("mode 7 pin directions wrong");
	a_bidir_pins:
		assert property (am_q == 4'h8 && $past(am_q) == 4'h8 |->
			o_p2_oe[7:3] == 5'h15)
		else $error("bidirectional control pins wrong");
	a_bidir_drive:
		assert property (am_q == 4'h8 && $past(am_q) == 4'h8 |->
			o_p0_oe == {8{~$past(i_p2_in[6])}})
		else $error("port 0 drive not tied to accept");
	a_grpb_out:
		assert property (bm_q == 4'h0 && $past(bm_q) == 4'h0 |->
			o_p1_oe == 8'hFF && o_p2_oe[2:0] == 3'h7)
		else $error("group B outputs not driven");
	a_upper_keep:
		assert property ((am_q == 4'h4 || am_q == 4'h6) && wr_of &&
			i_bus_addr == `PPC_ADDR_P2 ##1 !i_bus_wr |=> $stable(o_p2_out[4]) &&
			(am_q == 4'h6 || $stable(o_p2_out[5])))
		else $error("port 2 write changed upper bits");
	a_bit_single:
		assert property (am_q == 4'h0 && bm_q == 4'h0 && wr_of &&
			i_bus_addr == `PPC_ADDR_BIT ##1 !i_bus_wr |=>
			o_p2_out[$past(i_bus_wdata[2:0], 2)] == $past(i_bus_wdata[7], 2))
		else $error("bit command missed its bit");
	a_obf_ack:
		assert property (am_q == 4'h4 && $past(am_q) == 4'h4 &&
			$fell(i_p2_in[6]) && !i_bus_wr |-> ##2 o_p2_out[7])
		else $error("output full not cleared by accept");
	a_obf_write:
		assert property (am_q == 4'h4 && $past(am_q) == 4'h4 && wr_of &&
			i_bus_addr == `PPC_ADDR_P0 |-> ##2 !o_p2_out[7])
		else $error("output full not set by write");
endmodule // ppc_chk
bind ppc_port_controller ppc_chk #(.BUF_AW(BUF_AW)) chk_u (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_bus_rd(i_bus_rd),
	.i_bus_wr(i_bus_wr), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
	.o_bus_rdata(o_bus_rdata), .o_bus_ready(o_bus_ready),
	.i_p0_in(i_p0_in), .o_p0_out(o_p0_out), .o_p0_oe(o_p0_oe),
	.i_p1_in(i_p1_in), .o_p1_out(o_p1_out), .o_p1_oe(o_p1_oe),
	.i_p2_in(i_p2_in), .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe));
`default_nettype wire

// ### tb/ppc_peer.sv
// Peripheral model that strobes bytes in and accepts bytes out.
`timescale 1ns/1ns
`default_nettype none
module ppc_peer (
	// Clock and input-full flag from the controller.
	input wire logic i_sys_clk,
	input wire logic i_full,
	// Data and low-active strobes toward the controller.
	output logic [7:0] o_data,
	output logic o_stb_n,
	output logic o_acc_n
);
	initial
	begin
		o_data = 8'h00;
		o_stb_n = 1'b1;
		o_acc_n = 1'b1;
	end
	// Send one byte, first waiting up to 100 cycles while the controller reports full.
	task automatic send(input logic [7:0] d);
		int n;
		n = 0;
		while (i_full !== 1'b0 && n < 100)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		@(negedge i_sys_clk);
		o_data = d;
		o_stb_n = 1'b0;
		repeat (3) @(negedge i_sys_clk);
		o_stb_n = 1'b1;
		@(negedge i_sys_clk);
		// Released data is not held; show the inverse instead.
		o_data = ~d;
	endtask
	// Accept the output byte; called only when ready to receive.
	task automatic take(input int len);
		@(negedge i_sys_clk);
		o_acc_n = 1'b0;
		repeat (len) @(negedge i_sys_clk);
		o_acc_n = 1'b1;
	endtask
endmodule // ppc_peer
`default_nettype wire

// ### tb/parallel_port_handshake_controller_bench.sv
// Self-checking bench for the port controller and its peripheral.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_consts.vh"
module parallel_port_handshake_controller_bench;
	logic i_sys_clk, i_reset, rd, wr, rdy, stb_n, acc_n;
	logic [15:0] addr;
	logic [7:0] wd, rdata, p0o, p0e, p1o, p1e, p2o, p2e, pd, p1x, p2x, ex;
	wire [7:0] p0i, p1i, p2i;
	int errors, cmp_count, waited;
	// Each pin shows the controller where it drives, else the outside.
	assign p0i = (p0o & p0e) | (pd & ~p0e);
	assign p1i = (p1o & p1e) | (p1x & ~p1e);
	assign p2i = (p2o & p2e) |
		({p2x[7], acc_n, p2x[5], stb_n, p2x[3:0]} & ~p2e);
	ppc_port_controller #(.BUF_AW(1)) dut_u (.i_sys_clk(i_sys_clk),
		.i_reset(i_reset), .i_bus_rd(rd), .i_bus_wr(wr), .i_bus_addr(addr),
		.i_bus_wdata(wd), .o_bus_rdata(rdata), .o_bus_ready(rdy),
		.i_p0_in(p0i), .o_p0_out(p0o), .o_p0_oe(p0e), .i_p1_in(p1i),
		.o_p1_out(p1o), .o_p1_oe(p1e), .i_p2_in(p2i), .o_p2_out(p2o),
		.o_p2_oe(p2e));
	ppc_peer peer_u (.i_sys_clk(i_sys_clk), .i_full(p2o[5]), .o_data(pd),
		.o_stb_n(stb_n), .o_acc_n(acc_n));
	task automatic check(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	// One request pulse, then a bounded wait for the answer.
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge i_sys_clk);
		rd = ~w;
		wr = w;
		addr = a;
		wd = d;
		@(negedge i_sys_clk);
		rd = 1'b0;
		wr = 1'b0;
		waited = 0;
		while (rdy !== 1'b1 && waited < 300)
		begin
			@(negedge i_sys_clk);
			waited++;
		end
		check(rdy, "no answer");
		// Let the registered pins catch up with a written latch.
		if (w)
			@(negedge i_sys_clk);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		check(rdata === e, "read data");
	endtask
	// Hold accept low and look at port 0 while it should drive.
	task automatic drive_chk(input logic [7:0] e);
		fork
			peer_u.take(4);
			begin
				repeat (3) @(negedge i_sys_clk);
				check(p0e === 8'hFF && p0o === e, "port 0 drive");
			end
		join
	endtask
	task automatic finish_test;
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	// Watchdog: the sequence needs well under this many cycles.
	initial
	begin
		repeat (6000) @(posedge i_sys_clk);
		errors++;
		$display("unexpected at %0t: timeout", $time);
		finish_test();
	end
	initial
	begin
		{rd, wr, addr, wd} = '0;
		i_reset = 1'b1;
		p1x = 8'h5C;
		p2x = 8'hA6;
		repeat (2) @(negedge i_sys_clk);
		i_reset = 1'b0;
		rdc(`PPC_ADDR_CFG, 8'h33);
		rdc(`PPC_ADDR_P1, 8'h5C);
		p1x = 8'hC5;
		rdc(`PPC_ADDR_P1, 8'hC5);
		rdc(`PPC_ADDR_P2, 8'hF6);
		p2x = 8'h09;
		rdc(`PPC_ADDR_P2, 8'h59);
		for (int c = 5; c < 8; c += 2)
		begin
			xfer(1'b1, `PPC_ADDR_CFG, 8'(c));
			rdc(`PPC_ADDR_CFG, 8'h03);
		end
		xfer(1'b1, `PPC_ADDR_CFG, 8'h00);
		xfer(1'b1, `PPC_ADDR_P1, 8'hA5);
		rdc(`PPC_ADDR_P1, 8'hA5);
		check(p1o === 8'hA5 && p1e === 8'hFF, "port 1 pins");
		xfer(1'b1, `PPC_ADDR_P0, 8'h3C);
		rdc(`PPC_ADDR_P0, 8'h3C);
		xfer(1'b1, `PPC_ADDR_P2, 8'h00);
		ex = 8'h00;
		for (int i = 0; i < 16; i++)
		begin
			xfer(1'b1, `PPC_ADDR_BIT, {i < 8, 4'h0, 3'(i)});
			ex[i % 8] = (i < 8);
			rdc(`PPC_ADDR_P2, ex);
		end
		xfer(1'b1, `PPC_ADDR_CFG, 8'h40);
		xfer(1'b1, `PPC_ADDR_P2, 8'hFF);
		check(p2o[5:4] === 2'h0 && p2o[2:0] === 3'h7, "upper kept");
		xfer(1'b1, `PPC_ADDR_P0, 8'h5A);
		check(p0o === 8'h5A && p2o[7] === 1'b0, "output held");
		peer_u.take(3);
		check(p2o[7] === 1'b1 && p2o[3] === 1'b0, "gated accept");
		xfer(1'b1, `PPC_ADDR_BIT, 8'h86);
		xfer(1'b1, `PPC_ADDR_P0, 8'h11);
		peer_u.take(3);
		@(negedge i_sys_clk);
		check(p2o[3] === 1'b1, "irq passed");
		xfer(1'b1, `PPC_ADDR_CFG, 8'h40);
		check(p2o[3] === 1'b0, "irq enable kept");
		xfer(1'b1, `PPC_ADDR_P0, 8'h22);
		fork
			xfer(1'b1, `PPC_ADDR_SYNC, 8'h77);
			begin
				repeat (8) @(negedge i_sys_clk);
				peer_u.take(3);
			end
		join
		check(waited >= 8 && p0o === 8'h77, "sync write");
		xfer(1'b1, `PPC_ADDR_CFG, 8'h70);
		fork
			rdc(`PPC_ADDR_SYNC, 8'hC3);
			begin
				repeat (8) @(negedge i_sys_clk);
				peer_u.send(8'hC3);
			end
		join
		check(waited >= 8, "sync read early");
		peer_u.send(8'hA1);
		peer_u.send(8'hB2);
		check(p2o[5] === 1'b1, "input full");
		rdc(`PPC_ADDR_P0, 8'hA1);
		rdc(`PPC_ADDR_P0, 8'hB2);
		@(negedge i_sys_clk);
		check(p2o[5] === 1'b0, "input full stuck");
		xfer(1'b1, `PPC_ADDR_CFG, 8'h80);
		xfer(1'b1, `PPC_ADDR_P0, 8'h96);
		check(p0e === 8'h00, "port 0 not floating");
		drive_chk(8'h96);
		peer_u.send(8'h69);
		rdc(`PPC_ADDR_P0, 8'h69);
		drive_chk(8'h96);
		finish_test();
	end
endmodule // parallel_port_handshake_controller_bench
`default_nettype wire
